// >>> core/tcf_cam_entry.sv
`timescale 1ns/1ps
module tcf_cam_entry
  import tcf_pkg::*;
(
  // Clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 reset_i,
  // Control
  input  wire logic                 load_i,
  input  wire logic                 inval_i,
  input  wire tcf_tag_s             tag_i,
  input  wire logic [TCF_VPN_W-1:0] ppn_i,
  input  wire tcf_tag_s             probe_i,
  // Results
  output logic                      valid_o,
  output logic                      match_o,
  output logic                      wprot_o,
  output logic [TCF_VPN_W-1:0]      ppn_o
);

  tcf_tag_s tag;
  logic     valid;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      valid <= 1'b0;
    end else if (load_i) begin
      valid <= 1'b1;
    end else if (inval_i) begin
      valid <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (load_i) begin
      tag   <= tag_i;
      ppn_o <= ppn_i;
    end
  end

  // Parallel compare of page, function code and task alias
  wire tag_eq = (tag.vpn == probe_i.vpn) && (tag.fc == probe_i.fc) &&
                (tag.alias_id == probe_i.alias_id);
  assign match_o = valid && tag_eq;
  assign valid_o = valid;
  assign wprot_o = tag.wprot;

endmodule

// >>> core/tcf_front_end.sv
`timescale 1ns/1ps
// Functional notes
// - Sixty-four entry fully associative translation cache of descriptors.
// - Each entry tag holds logical page and rights, compared in parallel.
// - Each tag has a companion physical page returned on a hit.
// - Full cache victim chosen by pseudo least-recently-used tree.
// - Eight most recent root pointers cached, each with a task alias.
// - Cache entries qualified by task alias so several tasks coexist.
// - Any change on logical address inputs starts lookup and rights check.
// - Lookup starts on new address, not waiting for bus strobes.
// - Accesses to own register window decoded internally.
// - Device starts memory cycles only for table searches.
// - No shared clock assumed with main processor; logical bus inputs synchronised.
// - Three 64-bit roots: user, supervisor and DMA tables.
// - Logical address is 32 bits plus 4-bit function code, both matched.
// - Miss aborts master cycle, walks tables, installs descriptor; master retries.
// - Access level from upper address bits; non-supervisor level below current level faults.
module tcf_front_end
  import tcf_pkg::*;
#(
  parameter int LEVEL_BITS = TCF_LEVEL_W
) (
  // Clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  reset_i,
  // Logical bus, asynchronous to clk_i
  input  wire tcf_lbus_s             lbus_i,
  // Configuration
  input  wire logic [TCF_ROOT_W-1:0] user_table_root_i,
  input  wire logic [TCF_ROOT_W-1:0] supervisor_table_root_i,
  input  wire logic [TCF_ROOT_W-1:0] dma_table_root_i,
  input  wire logic                  root_load_i,
  input  wire logic [2:0]            current_level_i,
  input  wire logic                  flush_all_i,
  // Translation result
  output logic [TCF_ADDR_W-1:0]      paddr_o,
  output logic                       hit_o,
  output logic                       abort_o,
  output logic                       fault_o,
  output logic                       reg_sel_o,
  // Table search port to physical memory
  output logic                       walk_req_o,
  output logic [TCF_ROOT_W-1:0]      walk_root_o,
  output logic [TCF_ADDR_W-1:0]      walk_addr_o,
  output logic [TCF_FC_W-1:0]        walk_fc_o,
  input  wire logic                  walk_done_i,
  input  wire tcf_desc_s             walk_desc_i
);

  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0001,
    ST_LOOKUP = 4'b0010,
    ST_WALK   = 4'b0100,
    ST_FILL   = 4'b1000
  } tcf_state_e;

  // Three-stage synchroniser for the asynchronous logical bus
  tcf_lbus_s s1, s2, s3, cur;
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end else begin
      s1 <= lbus_i;
      s2 <= s1;
      s3 <= s2;
    end
  end
  wire stable = (s2 == s3);
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      cur <= '0;
    end else if (stable) begin
      cur <= s3;
    end
  end

  // Transition sense: any address or function code bit changes
  wire addr_changed = stable && ((s3.addr != cur.addr) || (s3.fc != cur.fc));

  // Internal register window decode
  wire reg_hit = (cur.fc == TCF_FC_CPU_SPACE) &&
                 (cur.addr[TCF_REG_HI_POS +: 4] == TCF_REG_ADDR_HI);

  // Root selection by function code
  wire is_dma   = (cur.fc == TCF_FC_DMA);
  wire is_super = cur.fc[TCF_FC_SUPER_BIT];
  wire [TCF_ROOT_W-1:0] sel_root = is_dma ? dma_table_root_i :
                                   is_super ? supervisor_table_root_i :
                                   user_table_root_i;

  // Root pointer cache with task aliases
  logic [TCF_ROOT_W-1:0]     rp_val [TCF_RP_ENTRIES];
  logic [TCF_RP_ENTRIES-1:0] rp_v;
  logic [TCF_ALIAS_W-1:0]    rp_next;
  logic [TCF_ALIAS_W-1:0]    alias_cur;
  logic [TCF_RP_ENTRIES-1:0] rp_match;
  for (genvar r = 0; r < TCF_RP_ENTRIES; r++) begin : g_rp
    assign rp_match[r] = rp_v[r] && (rp_val[r] == user_table_root_i);
  end
  logic [TCF_ALIAS_W-1:0] rp_hit_idx;
  always_comb begin
    rp_hit_idx = '0;
    for (int r = 0; r < TCF_RP_ENTRIES; r++) begin
      if (rp_match[r]) rp_hit_idx = TCF_ALIAS_W'(r);
    end
  end
  wire rp_any = |rp_match;
  // Alias being replaced: its translations must go
  wire rp_evict = root_load_i && !rp_any && rp_v[rp_next];

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      rp_v      <= TCF_RPV_RST;
      rp_next   <= '0;
      alias_cur <= '0;
    end else begin
      if (flush_all_i) begin
        rp_v <= TCF_RPV_RST;
      end
      // Root loaded with a flush is kept: allocation wins over the clear
      if (root_load_i && rp_any && !flush_all_i) begin
        alias_cur <= rp_hit_idx;
      end else if (root_load_i) begin
        rp_v[rp_next] <= 1'b1;
        alias_cur     <= rp_next;
        rp_next       <= rp_next + 1'b1;
      end
    end
  end
  always_ff @(posedge clk_i) begin
    if (root_load_i && (!rp_any || flush_all_i)) begin
      rp_val[rp_next] <= user_table_root_i;
    end
  end

  // Translation cache entries
  tcf_tag_s                  probe, fill_tag;
  logic [TCF_ENTRIES-1:0]    e_valid, e_match, e_wprot, e_load, e_inval;
  logic [TCF_VPN_W-1:0]      e_ppn [TCF_ENTRIES];
  logic [TCF_IDX_W-1:0]      victim;
  tcf_desc_s                 desc;

  assign probe.vpn      = cur.addr[TCF_ADDR_W-1:TCF_PAGE_SHIFT];
  assign probe.fc       = cur.fc;
  assign probe.alias_id = is_dma || is_super ? '0 : alias_cur;
  assign probe.wprot    = 1'b0;
  assign fill_tag.vpn      = desc.vpn;
  assign fill_tag.fc       = desc.fc;
  assign fill_tag.alias_id = probe.alias_id;
  assign fill_tag.wprot    = desc.wprot;

  tcf_state_e state, next_state;

  for (genvar e = 0; e < TCF_ENTRIES; e++) begin : g_ent
    assign e_load[e]  = (state == ST_FILL) && (victim == TCF_IDX_W'(e));
    // Evicted alias may be reused: drop every entry except the one being filled that cycle, whatever the current space
    assign e_inval[e] = flush_all_i || rp_evict;
    tcf_cam_entry u_ent (
      .clk_i   (clk_i),
      .reset_i (reset_i),
      .load_i  (e_load[e]),
      .inval_i (e_inval[e]),
      .tag_i   (fill_tag),
      .ppn_i   (desc.ppn),
      .probe_i (probe),
      .valid_o (e_valid[e]),
      .match_o (e_match[e]),
      .wprot_o (e_wprot[e]),
      .ppn_o   (e_ppn[e])
    );
  end

  logic [TCF_IDX_W-1:0] hit_idx;
  always_comb begin
    hit_idx = '0;
    for (int e = 0; e < TCF_ENTRIES; e++) begin
      if (e_match[e]) hit_idx = TCF_IDX_W'(e);
    end
  end
  wire any_hit = |e_match;

  // Pseudo-LRU tree: bit points away from the most recent side
  logic [TCF_ENTRIES-2:0] plru;
  logic [TCF_IDX_W-1:0]   plru_vic;
  always_comb begin
    logic [TCF_IDX_W-1:0] node;
    node     = '0;
    plru_vic = '0;
    for (int l = 0; l < TCF_IDX_W; l++) begin
      plru_vic[TCF_IDX_W-1-l] = plru[int'(node)];
      node = TCF_IDX_W'(2 * int'(node) + 1 + int'(plru[int'(node)]));
    end
  end
  logic                 has_free;
  logic [TCF_IDX_W-1:0] free_idx;
  always_comb begin
    has_free = 1'b0;
    free_idx = '0;
    for (int e = TCF_ENTRIES - 1; e >= 0; e--) begin
      if (!e_valid[e]) begin
        has_free = 1'b1;
        free_idx = TCF_IDX_W'(e);
      end
    end
  end
  wire [TCF_IDX_W-1:0] touch_idx = (state == ST_FILL) ? victim : hit_idx;
  wire                 touch     = (state == ST_FILL) || (state == ST_LOOKUP && any_hit);

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      plru <= '0;
    end else if (touch) begin
      for (int l = 0; l < TCF_IDX_W; l++) begin
        plru[(1 << l) - 1 + int'(touch_idx >> (TCF_IDX_W - l))] <=
          !touch_idx[TCF_IDX_W-1-l];
      end
    end
  end

  // Access level from upper address bits
  wire [2:0] req_level = (LEVEL_BITS == 0) ? 3'h0 :
                         3'(cur.addr[TCF_ADDR_W-1 -: 3] >> (3 - LEVEL_BITS));
  wire level_fault = !is_super && (req_level < current_level_i);
  wire wp_fault    = e_wprot[hit_idx] && !cur.rw;

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE:   if (addr_changed) next_state = ST_LOOKUP;
      ST_LOOKUP: begin
        if (addr_changed) next_state = ST_LOOKUP;
        else if (!any_hit && !reg_hit && !level_fault) next_state = ST_WALK;
        else next_state = ST_IDLE;
      end
      ST_WALK:   if (walk_done_i) next_state = ST_FILL;
      ST_FILL:   next_state = ST_LOOKUP;
      default:   next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state       <= ST_IDLE;
      victim      <= '0;
      desc        <= '0;
      hit_o       <= 1'b0;
      abort_o     <= 1'b0;
      fault_o     <= 1'b0;
      reg_sel_o   <= 1'b0;
      paddr_o     <= '0;
      walk_req_o  <= 1'b0;
      walk_root_o <= TCF_ROOT_RST;
      walk_addr_o <= '0;
      walk_fc_o   <= '0;
    end else begin
      state <= next_state;
      if (addr_changed) begin
        hit_o   <= 1'b0;
        abort_o <= 1'b0;
        fault_o <= 1'b0;
      end else if (state == ST_LOOKUP) begin
        hit_o     <= any_hit && !level_fault && !wp_fault && !reg_hit;
        fault_o   <= !reg_hit && (level_fault || (any_hit && wp_fault));
        abort_o   <= !reg_hit && !any_hit && !level_fault;
        reg_sel_o <= reg_hit;
        paddr_o   <= {e_ppn[hit_idx], cur.addr[TCF_PAGE_SHIFT-1:0]};
      end
      if (state == ST_LOOKUP && next_state == ST_WALK) begin
        walk_req_o  <= 1'b1;
        walk_root_o <= sel_root;
        walk_addr_o <= cur.addr;
        walk_fc_o   <= cur.fc;
        victim      <= has_free ? free_idx : plru_vic;
      end else if (walk_done_i) begin
        walk_req_o <= 1'b0;
        desc       <= walk_desc_i;
      end
    end
  end

  AST_ABORT_WALK: assert property (@(posedge clk_i) disable iff (reset_i)
    $rose(abort_o) |-> walk_req_o)
    else $error("abort without table search");
  AST_WALK_ONLY_ON_MISS: assert property (@(posedge clk_i) disable iff (reset_i)
    $rose(walk_req_o) |-> $past(state) == ST_LOOKUP && !$past(any_hit))
    else $error("table search started without a miss");
  AST_HIT_NOT_ABORT: assert property (@(posedge clk_i) disable iff (reset_i)
    !(hit_o && abort_o))
    else $error("hit and abort together");
  AST_CHANGE_STARTS: assert property (@(posedge clk_i) disable iff (reset_i)
    addr_changed && state != ST_WALK |=> state == ST_LOOKUP)
    else $error("address change did not start lookup");
  AST_FILL_HITS: assert property (@(posedge clk_i) disable iff (reset_i)
    state == ST_FILL |=> e_valid[victim])
    else $error("fill did not install entry");
  AST_FAULT_LEVEL: assert property (@(posedge clk_i) disable iff (reset_i)
    state == ST_LOOKUP && !addr_changed && !reg_hit && level_fault |=> fault_o)
    else $error("level violation not faulted");
  AST_REG_NO_WALK: assert property (@(posedge clk_i) disable iff (reset_i)
    state == ST_LOOKUP && !addr_changed && reg_hit |=> !walk_req_o && reg_sel_o)
    else $error("register access translated");
  AST_FLUSH_EMPTY: assert property (@(posedge clk_i) disable iff (reset_i)
    flush_all_i && state != ST_FILL |=> e_valid == TCF_VALID_RST)
    else $error("flush left valid entries");

  COV_HIT:   cover property (@(posedge clk_i) disable iff (reset_i) $rose(hit_o));
  COV_MISS:  cover property (@(posedge clk_i) disable iff (reset_i) state == ST_FILL);
  COV_FULL:  cover property (@(posedge clk_i) disable iff (reset_i) &e_valid ##1 state == ST_FILL);
  COV_FAULT: cover property (@(posedge clk_i) disable iff (reset_i) $rose(fault_o));

endmodule

// >>> include/tcf_pkg.sv
package tcf_pkg;

  // Geometry
  localparam int TCF_ENTRIES      = 64;
  localparam int TCF_RP_ENTRIES   = 8;
  localparam int TCF_ADDR_W       = 32;
  localparam int TCF_FC_W         = 4;
  localparam int TCF_PAGE_SHIFT   = 12;
  localparam int TCF_ROOT_W       = 64;
  localparam int TCF_ALIAS_W      = 3;
  localparam int TCF_LEVEL_W      = 3;
  localparam int TCF_IDX_W        = 6;

  // Register window decode: CPU space with upper address match
  localparam logic [3:0]  TCF_FC_CPU_SPACE = 4'h7;
  localparam logic [3:0]  TCF_REG_ADDR_HI  = 4'h2;
  localparam int          TCF_REG_HI_POS   = 16;

  // Function code bit that marks supervisor accesses, DMA function code
  localparam int          TCF_FC_SUPER_BIT = 2;
  localparam logic [3:0]  TCF_FC_DMA       = 4'h8;

  // Reset values
  localparam logic [TCF_ENTRIES-1:0]    TCF_VALID_RST = '0;
  localparam logic [TCF_RP_ENTRIES-1:0] TCF_RPV_RST   = '0;
  localparam logic [TCF_ROOT_W-1:0]     TCF_ROOT_RST  = '0;

  localparam int TCF_VPN_W = TCF_ADDR_W - TCF_PAGE_SHIFT;

  typedef struct packed {
    logic [TCF_VPN_W-1:0]   vpn;
    logic [TCF_FC_W-1:0]    fc;
    logic [TCF_ALIAS_W-1:0] alias_id;
    logic                   wprot;
  } tcf_tag_s;

  typedef struct packed {
    logic [TCF_ADDR_W-1:0] addr;
    logic [TCF_FC_W-1:0]   fc;
    logic                  as_n;
    logic                  rw;
  } tcf_lbus_s;

  typedef struct packed {
    logic [TCF_VPN_W-1:0] vpn;
    logic [TCF_VPN_W-1:0] ppn;
    logic [TCF_FC_W-1:0]  fc;
    logic                 wprot;
  } tcf_desc_s;

endpackage

// >>> tb/tcf_mem_model.sv
`timescale 1ns/1ps
// Physical memory side: answers table searches only, after delay_i cycles
module tcf_mem_model
  import tcf_pkg::*;
(
  // Clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  reset_i,
  // Search request
  input  wire logic                  walk_req_i,
  input  wire logic [TCF_ADDR_W-1:0] walk_addr_i,
  input  wire logic [TCF_FC_W-1:0]   walk_fc_i,
  input  wire logic [7:0]            delay_i,
  // Answer
  output logic                       walk_done_o,
  output tcf_desc_s                  walk_desc_o
);
  localparam logic [TCF_VPN_W-1:0] PPN_KEY = 20'hf0f0f;
  logic [7:0] wait_cnt;
  logic       served;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      wait_cnt    <= '0;
      served      <= 1'b0;
      walk_done_o <= 1'b0;
      walk_desc_o <= '0;
    end else begin
      walk_done_o <= 1'b0;
      // Released bus alternates between the last descriptor and its inverse
      walk_desc_o <= ~walk_desc_o;
      if (!walk_req_i) begin
        served   <= 1'b0;
        wait_cnt <= '0;
      end else if (!served) begin
        if (wait_cnt == delay_i) begin
          walk_done_o <= 1'b1;
          served      <= 1'b1;
          walk_desc_o <= '{vpn: walk_addr_i[31:12], ppn: walk_addr_i[31:12] ^ PPN_KEY,
                           fc: walk_fc_i, wprot: (walk_addr_i[31:28] == 4'hd)};
        end else begin
          wait_cnt <= wait_cnt + 8'h01;
        end
      end
    end
  end
endmodule

// >>> tb/test_translation_cache_front_end.sv
`timescale 1ns/1ps
module test_translation_cache_front_end;
  import tcf_pkg::*;
  localparam logic [31:0] PARK = 32'h0002_0000;
  logic            clk_i = 1'b0;
  logic            reset_i = 1'b1;
  tcf_lbus_s       lbus_i = '{addr: 32'h0, fc: 4'h0, as_n: 1'b1, rw: 1'b1};
  logic [63:0]     root_u = 64'h11;
  logic [63:0]     root_s = 64'h22;
  logic [63:0]     root_d = 64'h33;
  logic            root_load_i = 1'b0;
  logic [2:0]      current_level_i = 3'h0;
  logic            flush_all_i = 1'b0;
  logic [31:0]     paddr_o;
  logic            hit_o, abort_o, fault_o, reg_sel_o, walk_req_o, walk_done_i;
  logic [63:0]     walk_root_o, last_root;
  logic [31:0]     walk_addr_o;
  logic [3:0]      walk_fc_o;
  tcf_desc_s       walk_desc_i;
  logic [7:0]      mem_delay = 8'h01;
  logic            s_hit, s_abort, s_fault;
  logic [31:0]     s_paddr;
  int              err_total = 0;
  int              check_count = 0;
  int              walks = 0;

  always #5 clk_i = ~clk_i;

  tcf_front_end uut (.clk_i(clk_i), .reset_i(reset_i), .lbus_i(lbus_i),
    .user_table_root_i(root_u), .supervisor_table_root_i(root_s),
    .dma_table_root_i(root_d), .root_load_i(root_load_i),
    .current_level_i(current_level_i), .flush_all_i(flush_all_i), .paddr_o(paddr_o),
    .hit_o(hit_o), .abort_o(abort_o), .fault_o(fault_o), .reg_sel_o(reg_sel_o),
    .walk_req_o(walk_req_o), .walk_root_o(walk_root_o), .walk_addr_o(walk_addr_o),
    .walk_fc_o(walk_fc_o), .walk_done_i(walk_done_i), .walk_desc_i(walk_desc_i));

  tcf_mem_model mem (.clk_i(clk_i), .reset_i(reset_i), .walk_req_i(walk_req_o),
    .walk_addr_i(walk_addr_o), .walk_fc_i(walk_fc_o), .delay_i(mem_delay),
    .walk_done_o(walk_done_i), .walk_desc_o(walk_desc_i));

  always @(posedge clk_i) begin
    if (walk_req_o === 1'b1) last_root <= walk_root_o;
    if (walk_req_o === 1'b1 && walk_done_i === 1'b1) walks++;
  end

  task automatic close_out;
    $display("checks %0d, mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk_bit(input string what, input logic exp, input logic got);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s: expected %b, seen %b", what, exp, got);
    end
  endtask

  task automatic chk_word(input string what, input logic [63:0] exp, input logic [63:0] got);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  // Strobes stay negated: results must come from the address change alone
  task automatic drive(input logic [31:0] a, input logic [3:0] f);
    @(posedge clk_i);
    #1;
    lbus_i.addr = a;
    lbus_i.fc = f;
    repeat (8) @(posedge clk_i);
    #1;
    s_hit = hit_o;
    s_abort = abort_o;
    s_fault = fault_o;
    s_paddr = paddr_o;
  endtask

  // Park in own register window, present, then let any search finish
  task automatic access(input logic [31:0] a, input logic [3:0] f);
    int n;
    n = 0;
    drive(PARK, TCF_FC_CPU_SPACE);
    drive(a, f);
    while (walk_req_o === 1'b1 && n < 200) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 200) begin
      err_total++;
      $display("unexpected search length: expected below 200, seen %0d", n);
    end
    repeat (3) @(posedge clk_i);
    #1;
  endtask

  task automatic expect_hit(input logic [31:0] a, input logic [3:0] f);
    int w;
    w = walks;
    access(a, f);
    chk_bit("hit", 1'b1, s_hit);
    chk_word("paddr", {32'h0, a[31:12] ^ 20'hf0f0f, a[11:0]}, {32'h0, s_paddr});
    chk_word("searches", w, walks);
  endtask

  task automatic expect_miss(input logic [31:0] a, input logic [3:0] f);
    int w;
    w = walks;
    access(a, f);
    chk_bit("abort", 1'b1, s_abort);
    chk_bit("hit on miss", 1'b0, s_hit);
    chk_word("searches", w + 1, walks);
  endtask

  task automatic load_root(input logic [63:0] r);
    @(posedge clk_i);
    #1;
    root_u = r;
    root_load_i = 1'b1;
    @(posedge clk_i);
    #1;
    root_load_i = 1'b0;
    repeat (4) @(posedge clk_i);
  endtask

  task automatic pulse_flush;
    @(posedge clk_i);
    #1;
    flush_all_i = 1'b1;
    @(posedge clk_i);
    #1;
    flush_all_i = 1'b0;
    repeat (4) @(posedge clk_i);
  endtask

  task automatic t_reset;
    chk_bit("hit after reset", 1'b0, hit_o);
    chk_bit("search after reset", 1'b0, walk_req_o);
  endtask

  task automatic t_miss_retry;
    expect_miss(32'he000_4000, 4'h1);
    expect_hit(32'he000_4000, 4'h1);
    drive(32'he000_4abc, 4'h1);
    chk_bit("hit on offset change", 1'b1, s_hit);
    chk_word("paddr offset", {32'h0, 20'he0004 ^ 20'hf0f0f, 12'habc}, {32'h0, s_paddr});
    expect_miss(32'he000_4000, 4'h2);
    expect_hit(32'he000_4000, 4'h1);
  endtask

  task automatic t_capacity;
    pulse_flush();
    expect_miss(32'he000_4000, 4'h1);
    for (int i = 1; i < 64; i++) expect_miss(32'he010_0000 + (i << 12), 4'h1);
    expect_hit(32'he000_4000, 4'h1);
    for (int i = 1; i < 64; i++) expect_hit(32'he010_0000 + (i << 12), 4'h1);
    expect_miss(32'he020_0000, 4'h1);
    expect_hit(32'he020_0000, 4'h1);
  endtask

  task automatic t_alias;
    // Root cache was emptied by the flush above
    load_root(64'h11);
    expect_miss(32'he030_0000, 4'h1);
    load_root(64'h44);
    expect_miss(32'he030_0000, 4'h1);
    chk_word("user root", 64'h44, last_root);
    expect_hit(32'he030_0000, 4'h1);
    load_root(64'h11);
    expect_hit(32'he030_0000, 4'h1);
  endtask

  task automatic t_roots;
    mem_delay = 8'h14;
    expect_miss(32'he040_0000, 4'h5);
    chk_word("supervisor root", root_s, last_root);
    expect_miss(32'he040_0000, TCF_FC_DMA);
    chk_word("dma root", root_d, last_root);
    expect_hit(32'he040_0000, 4'h5);
    mem_delay = 8'h01;
  endtask

  task automatic t_level;
    current_level_i = 3'h3;
    access(32'h0000_7000, 4'h1);
    chk_bit("fault low level", 1'b1, s_fault);
    access(32'he000_7000, 4'h1);
    chk_bit("fault high level", 1'b0, s_fault);
    lbus_i.rw = 1'b0;
    access(32'hd000_0000, 4'h1);
    access(32'hd000_0000, 4'h1);
    chk_bit("fault write protect", 1'b1, s_fault);
    chk_bit("hit on protected write", 1'b0, s_hit);
    lbus_i.rw = 1'b1;
    current_level_i = 3'h0;
  endtask

  task automatic t_regs;
    drive(PARK, TCF_FC_CPU_SPACE);
    chk_bit("register select", 1'b1, reg_sel_o);
    drive(32'h0003_0000, TCF_FC_CPU_SPACE);
    chk_bit("register select off", 1'b0, reg_sel_o);
    drive(PARK, 4'h1);
    chk_bit("register select fc", 1'b0, reg_sel_o);
  endtask

  task automatic t_flush;
    expect_hit(32'he030_0000, 4'h1);
    pulse_flush();
    expect_miss(32'he030_0000, 4'h1);
  endtask

  initial begin
    repeat (3) @(posedge clk_i);
    #1;
    reset_i = 1'b0;
    t_reset();
    load_root(64'h11);
    t_miss_retry();
    t_capacity();
    t_alias();
    t_roots();
    t_level();
    t_regs();
    t_flush();
    close_out();
  end

  initial begin
    #900000;
    err_total++;
    close_out();
  end
endmodule
